// File: include/metering_pkg.sv
// Package: register map, field positions, reset values and timing of the metering access path
package metering_pkg;

    // ------------------------------------------------------------------
    // Special function register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_POINTER    = 8'h91;
    localparam logic [7:0] ADDR_DATA_LOW   = 8'h92;
    localparam logic [7:0] ADDR_DATA_MID   = 8'h93;
    localparam logic [7:0] ADDR_DATA_HIGH  = 8'h94;
    localparam logic [7:0] ADDR_VRMS_LOW   = 8'hd1;
    localparam logic [7:0] ADDR_IRMS_LOW   = 8'hd4;
    localparam logic [7:0] ADDR_IRQEN_LOW  = 8'hd9;
    localparam logic [7:0] ADDR_IRQST_LOW  = 8'hdc;
    localparam logic [7:0] ADDR_WAVE1_LOW  = 8'he2;
    localparam logic [7:0] ADDR_WAVE2_LOW  = 8'he5;

    // ------------------------------------------------------------------
    // Pointer fields
    // ------------------------------------------------------------------
    localparam int         POINTER_DIR_BIT = 7;
    localparam int         POINTER_ADDR_W  = 7;

    // ------------------------------------------------------------------
    // Internal register widths in bytes, as reported by the core
    // ------------------------------------------------------------------
    localparam logic [1:0] WIDTH_ONE_BYTE  = 2'h1;
    localparam logic [1:0] WIDTH_TWO_BYTE  = 2'h2;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  POINTER_RESET  = 8'h00;
    localparam logic [7:0]  BYTE_RESET     = 8'h00;
    localparam logic [23:0] WORD_RESET     = 24'h000000;

    // ------------------------------------------------------------------
    // Timing: two synchroniser stages plus one strobe cycle
    // ------------------------------------------------------------------
    localparam int         TRANSFER_CYCLES = 3;

endpackage

// File: include/transfer_if.sv
// Interface: pointer-triggered request between bridge and transfer timer
`timescale 1ns/100ps
interface transfer_if;
    logic start;
    logic busy;
    logic done;

    modport bridge (output start, input busy, input done);
    modport timer  (input start, output busy, output done);
endinterface

// File: hw/transfer_timer.sv
// Transfer timer: paces one indirect access across into the metering core
`timescale 1ns/100ps
module transfer_timer
    import metering_pkg::*;
#(
    parameter int CYCLES = TRANSFER_CYCLES
) (
    input  wire logic  clk,
    input  wire logic  reset,
    transfer_if.timer  xfer
);

    // ------------------------------------------------------------------
    // Countdown
    // ------------------------------------------------------------------
    logic [3:0] count_q;
    logic [3:0] count_d;
    logic       busy_q;
    logic       last;

    assign last      = busy_q && (count_q == 4'h1);
    assign count_d   = xfer.start ? 4'(CYCLES) : (busy_q ? count_q - 4'h1 : count_q);
    assign xfer.busy = busy_q;
    assign xfer.done = last;

    always_ff @(posedge clk) begin
        if (reset) begin
            count_q <= 4'h0;
            busy_q  <= 1'b0;
        end else begin
            count_q <= count_d;
            busy_q  <= xfer.start | (busy_q & ~last);
        end
    end

endmodule // transfer_timer

// File: hw/metering_register_access.sv
// Bridge between the processor register bus and the metering core registers
//
// Summary of operation
// - Results direct; others via pointer and data
// - Interrupt bytes latch individually when read
// - High byte read latches whole 24 bits
// - Low/mid before high give previous capture
// - Pointer write: bit7 direction, bits6:0 address
// - Write direction copies data bytes inward
// - One-byte target takes low byte only
// - Metering core on slower, separate clock; here bridge and core model share clk, and the timer waits 3 clk cycles
// - Read loads data; one-byte zeroes upper
// - Low, mid, high bytes map LSB to MSB
`timescale 1ns/100ps
module metering_register_access
    import metering_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset,
    // Register bus
    input  wire logic [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_rd,
    output logic      [7:0]  sfr_rdata,
    // Direct results and interrupt registers exchanged with the metering core
    input  wire logic [23:0] voltage_rms_result,
    input  wire logic [23:0] current_rms_result,
    input  wire logic [23:0] waveform_sample_one,
    input  wire logic [23:0] waveform_sample_two,
    input  wire logic [23:0] metering_irq_status,
    output logic      [23:0] metering_irq_enable,
    output logic      [2:0]  irq_status_write,
    output logic      [7:0]  irq_status_wdata,
    // Indirect register port of the metering core
    output logic      [6:0]  mreg_addr,
    output logic      [23:0] mreg_wdata,
    output logic             mreg_wr,
    output logic             mreg_rd,
    input  wire logic [23:0] mreg_rdata,
    input  wire logic [1:0]  mreg_width,
    output logic             transfer_busy
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] pick_byte(input logic [23:0] w, input logic [1:0] idx);
        unique case (idx)
            2'h0:    pick_byte = w[7:0];
            2'h1:    pick_byte = w[15:8];
            default: pick_byte = w[23:16];
        endcase
    endfunction

    // Offset of addr within a three-byte group starting at base, 2'h3 if outside
    function automatic logic [1:0] group_index(input logic [7:0] addr, input logic [7:0] base);
        logic [7:0] diff;
        diff = addr - base;
        group_index = (diff < 8'h03) ? diff[1:0] : 2'h3;
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  pointer_q;
    logic [23:0] data_q;
    logic [23:0] data_d;
    logic [23:0] vrms_q;
    logic [23:0] irms_q;
    logic [23:0] wave1_q;
    logic [23:0] wave2_q;
    logic [23:0] irqst_q;
    logic [23:0] irqen_q;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;
    logic [2:0]  stw_q;
    logic [7:0]  stw_data_q;
    logic [6:0]  maddr_q;
    logic [23:0] mwdata_q;
    logic        mdir_q;

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    logic [1:0] idx_vrms;
    logic [1:0] idx_irms;
    logic [1:0] idx_wave1;
    logic [1:0] idx_wave2;
    logic [1:0] idx_irqst;
    logic [1:0] idx_irqen;
    logic [1:0] idx_data;
    logic       ptr_write;

    assign idx_vrms  = group_index(sfr_addr, ADDR_VRMS_LOW);
    assign idx_irms  = group_index(sfr_addr, ADDR_IRMS_LOW);
    assign idx_wave1 = group_index(sfr_addr, ADDR_WAVE1_LOW);
    assign idx_wave2 = group_index(sfr_addr, ADDR_WAVE2_LOW);
    assign idx_irqst = group_index(sfr_addr, ADDR_IRQST_LOW);
    assign idx_irqen = group_index(sfr_addr, ADDR_IRQEN_LOW);
    assign idx_data  = group_index(sfr_addr, ADDR_DATA_LOW);
    assign ptr_write = sfr_wr && (sfr_addr == ADDR_POINTER);

    // High-byte reads hit the group at index 2
    logic vrms_latch;
    logic irms_latch;
    logic wave1_latch;
    logic wave2_latch;
    assign vrms_latch  = sfr_rd && (idx_vrms  == 2'h2);
    assign irms_latch  = sfr_rd && (idx_irms  == 2'h2);
    assign wave1_latch = sfr_rd && (idx_wave1 == 2'h2);
    assign wave2_latch = sfr_rd && (idx_wave2 == 2'h2);

    // ------------------------------------------------------------------
    // Transfer timer
    // ------------------------------------------------------------------
    transfer_if xfer ();

    assign xfer.start    = ptr_write;
    assign transfer_busy = xfer.busy;

    transfer_timer #(
        .CYCLES (TRANSFER_CYCLES)
    ) u_timer (
        .clk   (clk),
        .reset (reset),
        .xfer  (xfer)
    );

    // ------------------------------------------------------------------
    // Indirect data path
    // ------------------------------------------------------------------
    logic [23:0] write_word;
    logic [23:0] read_word;
    logic        finish_read;

    // Upper bytes are zeroed so the core never sees stale lanes
    assign write_word = (mreg_width == WIDTH_ONE_BYTE) ? {16'h0000, data_q[7:0]} :
                        (mreg_width == WIDTH_TWO_BYTE) ? {8'h00, data_q[15:0]} :
                        data_q;
    assign read_word  = (mreg_width == WIDTH_ONE_BYTE) ? {16'h0000, mreg_rdata[7:0]} :
                        (mreg_width == WIDTH_TWO_BYTE) ? {8'h00, mreg_rdata[15:0]} :
                        mreg_rdata;
    assign finish_read = xfer.done && !mdir_q;

    always_comb begin
        data_d = data_q;
        if (finish_read) begin
            data_d = read_word;
        end else if (sfr_wr && (idx_data != 2'h3)) begin
            data_d[8*idx_data +: 8] = sfr_wdata;
        end
    end

    assign mreg_addr  = maddr_q;
    assign mreg_wdata = mwdata_q;
    assign mreg_wr    = xfer.done && mdir_q;
    assign mreg_rd    = xfer.done && !mdir_q;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    // Latching reads return the value captured in this very access
    always_comb begin
        rdata_d = 8'h00;
        if (sfr_addr == ADDR_POINTER) begin
            rdata_d = pointer_q;
        end else if (idx_data != 2'h3) begin
            rdata_d = pick_byte(data_q, idx_data);
        end else if (idx_vrms != 2'h3) begin
            rdata_d = vrms_latch ? voltage_rms_result[23:16] : pick_byte(vrms_q, idx_vrms);
        end else if (idx_irms != 2'h3) begin
            rdata_d = irms_latch ? current_rms_result[23:16] : pick_byte(irms_q, idx_irms);
        end else if (idx_wave1 != 2'h3) begin
            rdata_d = wave1_latch ? waveform_sample_one[23:16] : pick_byte(wave1_q, idx_wave1);
        end else if (idx_wave2 != 2'h3) begin
            rdata_d = wave2_latch ? waveform_sample_two[23:16] : pick_byte(wave2_q, idx_wave2);
        end else if (idx_irqst != 2'h3) begin
            rdata_d = pick_byte(metering_irq_status, idx_irqst);
        end else if (idx_irqen != 2'h3) begin
            rdata_d = pick_byte(irqen_q, idx_irqen);
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (reset) begin
            pointer_q  <= POINTER_RESET;
            data_q     <= WORD_RESET;
            vrms_q     <= WORD_RESET;
            irms_q     <= WORD_RESET;
            wave1_q    <= WORD_RESET;
            wave2_q    <= WORD_RESET;
            irqst_q    <= WORD_RESET;
            irqen_q    <= WORD_RESET;
            rdata_q    <= BYTE_RESET;
            stw_q      <= 3'h0;
            stw_data_q <= BYTE_RESET;
            maddr_q    <= 7'h00;
            mwdata_q   <= WORD_RESET;
            mdir_q     <= 1'b0;
        end else begin
            data_q     <= data_d;
            stw_q      <= 3'h0;
            stw_data_q <= sfr_wdata;
            if (sfr_rd) begin
                rdata_q <= rdata_d;
            end
            if (ptr_write) begin
                pointer_q <= sfr_wdata;
                mdir_q    <= sfr_wdata[POINTER_DIR_BIT];
                maddr_q   <= sfr_wdata[POINTER_ADDR_W-1:0];
            end
            if (xfer.done && mdir_q) begin
                mwdata_q <= write_word;
            end
            if (vrms_latch) begin
                vrms_q <= voltage_rms_result;
            end
            if (irms_latch) begin
                irms_q <= current_rms_result;
            end
            if (wave1_latch) begin
                wave1_q <= waveform_sample_one;
            end
            if (wave2_latch) begin
                wave2_q <= waveform_sample_two;
            end
            if (sfr_rd && (idx_irqst != 2'h3)) begin
                irqst_q[8*idx_irqst +: 8] <= pick_byte(metering_irq_status, idx_irqst);
            end
            if (sfr_wr && (idx_irqst != 2'h3)) begin
                stw_q[idx_irqst] <= 1'b1;
            end
            if (sfr_wr && (idx_irqen != 2'h3)) begin
                irqen_q[8*idx_irqen +: 8] <= sfr_wdata;
            end
        end
    end

    assign sfr_rdata           = rdata_q;
    assign metering_irq_enable = irqen_q;
    assign irq_status_write    = stw_q;
    assign irq_status_wdata    = stw_data_q;

endmodule // metering_register_access

// File: bench/metering_access_monitor.sv
// Checker: timing and data relations at the metering access path ports
`timescale 1ns/100ps
module metering_access_monitor
    import metering_pkg::*;
(
    input wire logic        clk,
    input wire logic        reset,
    input wire logic [7:0]  sfr_addr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_wr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [23:0] voltage_rms_result,
    input wire logic [23:0] metering_irq_enable,
    input wire logic [2:0]  irq_status_write,
    input wire logic [7:0]  irq_status_wdata,
    input wire logic [6:0]  mreg_addr,
    input wire logic [23:0] mreg_wdata,
    input wire logic        mreg_wr,
    input wire logic        mreg_rd,
    input wire logic [1:0]  mreg_width,
    input wire logic        transfer_busy
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire ptr_wr = sfr_wr && (sfr_addr == ADDR_POINTER);
    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    chk_read_strobe: assert property (ptr_wr && !sfr_wdata[7] |-> ##3 mreg_rd && !mreg_wr)
        else $error("indirect read strobe not three cycles after pointer");
    chk_write_strobe: assert property (ptr_wr && sfr_wdata[7] |-> ##3 mreg_wr && !mreg_rd)
        else $error("indirect write strobe not three cycles after pointer");
    chk_busy_span: assert property (ptr_wr |=> transfer_busy[*3] ##1 !transfer_busy)
        else $error("busy window not three cycles");
    chk_addr_select: assert property (ptr_wr |=> mreg_addr == $past(sfr_wdata[6:0]))
        else $error("internal address not taken from pointer");
    chk_strobe_quiet: assert property (!transfer_busy |-> !mreg_wr && !mreg_rd)
        else $error("strobe outside a pending transfer");
    chk_wdata_one: assert property (mreg_wr && mreg_width == WIDTH_ONE_BYTE |=> mreg_wdata[23:8] == 16'h0000)
        else $error("one byte write carries upper bytes");
    chk_wdata_two: assert property (mreg_wr && mreg_width == WIDTH_TWO_BYTE |=> mreg_wdata[23:16] == 8'h00)
        else $error("two byte write carries high byte");
    chk_irq_forward: assert property (sfr_wr && sfr_addr == ADDR_IRQST_LOW |=> irq_status_write == 3'h1 && irq_status_wdata == $past(sfr_wdata))
        else $error("status write not forwarded");
    chk_irq_mid: assert property
        (sfr_wr && sfr_addr == ADDR_IRQST_LOW + 8'h01
         |=> irq_status_write == 3'h2 && irq_status_wdata == $past(sfr_wdata))
        else $error("status middle byte write not forwarded");
    chk_irq_high: assert property
        (sfr_wr && sfr_addr == ADDR_IRQST_LOW + 8'h02
         |=> irq_status_write == 3'h4 && irq_status_wdata == $past(sfr_wdata))
        else $error("status high byte write not forwarded");
    chk_enable_low: assert property (sfr_wr && sfr_addr == ADDR_IRQEN_LOW |=> metering_irq_enable[7:0] == $past(sfr_wdata))
        else $error("enable low byte not written");
    chk_rms_fresh: assert property (sfr_rd && sfr_addr == ADDR_VRMS_LOW + 8'h02 |=> sfr_rdata == $past(voltage_rms_result[23:16]))
        else $error("high byte read not fresh");
endmodule // metering_access_monitor

bind metering_register_access metering_access_monitor u_metering_access_monitor (.clk, .reset,
    .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd, .sfr_rdata, .voltage_rms_result, .metering_irq_enable,
    .irq_status_write, .irq_status_wdata, .mreg_addr, .mreg_wdata, .mreg_wr, .mreg_rd, .mreg_width,
    .transfer_busy);

// File: bench/metering_core_model.sv
// Partner model: indirect register page of the metering core
`timescale 1ns/100ps
module metering_core_model (
    input  wire logic        clk,
    input  wire logic        reset,
    input  wire logic [6:0]  mreg_addr,
    input  wire logic [23:0] mreg_wdata,
    input  wire logic        mreg_wr,
    input  wire logic        mreg_rd,
    output logic      [23:0] mreg_rdata,
    output logic      [1:0]  mreg_width
);
    logic [23:0] mem [128];
    logic        wr_pend_q;
    logic [6:0]  wr_addr_q;
    // Narrow registers return ones above their width, so zero fill is proven
    wire logic [23:0] pad = (mreg_width == 2'h1) ? 24'hffff00 :
                            (mreg_width == 2'h2) ? 24'hff0000 : 24'h000000;
    assign mreg_width = (mreg_addr[1:0] == 2'h0) ? 2'h1 : (mreg_addr[1:0] == 2'h1) ? 2'h2 : 2'h3;
    assign mreg_rdata = mreg_rd ? (mem[mreg_addr] | pad) : ~mem[mreg_addr];
    // Data word follows the strobe by one cycle
    always_ff @(posedge clk) begin
        wr_pend_q <= mreg_wr & ~reset;
        wr_addr_q <= mreg_addr;
        if (wr_pend_q) mem[wr_addr_q] <= mreg_wdata;
    end
endmodule // metering_core_model

// File: bench/metering_register_access_test.sv
// Testbench: register bus scenarios against the metering access path
`timescale 1ns/100ps
module metering_register_access_test
    import metering_pkg::*;
();
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [7:0]  sfr_addr = 8'h00;
    logic [7:0]  sfr_wdata = 8'h00;
    logic        sfr_wr = 1'b0;
    logic        sfr_rd = 1'b0;
    logic [7:0]  sfr_rdata, irq_status_wdata, b;
    logic [23:0] res [4];
    logic [23:0] irq_live, metering_irq_enable, mreg_wdata, mreg_rdata, v, d, e;
    logic [2:0]  irq_status_write;
    logic [6:0]  mreg_addr, a;
    logic [1:0]  mreg_width;
    logic        mreg_wr, mreg_rd, transfer_busy;
    logic        rd_seen_q = 1'b0;
    logic [7:0]  exp_q [$];
    logic [7:0]  base [4] = '{ADDR_VRMS_LOW, ADDR_IRMS_LOW, ADDR_WAVE1_LOW, ADDR_WAVE2_LOW};
    int          num_errors = 0;
    int          cmp_count = 0;
    int          seed, i, w;

    always #4 clk = ~clk;

    metering_register_access u_metering_register_access (.clk, .reset, .sfr_addr, .sfr_wdata,
        .sfr_wr, .sfr_rd, .sfr_rdata, .voltage_rms_result(res[0]), .current_rms_result(res[1]),
        .waveform_sample_one(res[2]), .waveform_sample_two(res[3]), .metering_irq_status(irq_live),
        .metering_irq_enable, .irq_status_write, .irq_status_wdata, .mreg_addr, .mreg_wdata,
        .mreg_wr, .mreg_rd, .mreg_rdata, .mreg_width, .transfer_busy);
    metering_core_model u_metering_core_model (.clk, .reset, .mreg_addr, .mreg_wdata, .mreg_wr,
        .mreg_rd, .mreg_rdata, .mreg_width);

    // ------------------------------------------------------------------
    // Bus tasks and comparison
    // ------------------------------------------------------------------
    // One idle cycle after each access keeps strobes from being reassigned
    task automatic acc(input logic wr, input logic [7:0] ad, input logic [7:0] dt);
        sfr_wr = wr;
        sfr_rd = !wr;
        sfr_addr = ad;
        sfr_wdata = dt;
        @(posedge clk);
        #1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        @(posedge clk);
        #1;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] ex);
        exp_q.push_back(ex);
        acc(1'b0, ad, 8'h00);
    endtask
    task automatic check(input logic [23:0] got, input logic [23:0] ex);
        cmp_count++;
        if (got !== ex) begin
            num_errors++;
            $display("[FAIL] %0t: got %h expected %h", $time, got, ex);
        end
    endtask
    task automatic wait_xfer();
        repeat (4) @(posedge clk);
        #1;
    endtask
    task automatic stop_test();
        $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk) begin
        rd_seen_q <= sfr_rd;
        if (rd_seen_q) begin
            #0.5;
            check({16'h0000, sfr_rdata}, {16'h0000, exp_q.pop_front()});
        end
    end

    initial begin
        #100000;
        num_errors++;
        $display("[FAIL] %0t: watchdog expired", $time);
        stop_test();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin
        seed = $urandom(32'h95245911);
        for (i = 0; i < 4; i++) res[i] = 24'h000000;
        irq_live = 24'h000000;
        repeat (5) @(posedge clk);
        #1;
        reset = 1'b0;
        rd(ADDR_POINTER, POINTER_RESET);
        rd(ADDR_DATA_HIGH, BYTE_RESET);
        rd(8'h00, 8'h00);
        for (i = 0; i < 4; i++) begin
            res[i] = 24'($urandom);
            v = res[i];
            rd(base[i] + 8'h02, v[23:16]);
            res[i] = 24'($urandom);
            rd(base[i] + 8'h01, v[15:8]);
            rd(base[i], v[7:0]);
        end
        for (i = 0; i < 3; i++) begin
            irq_live = 24'($urandom);
            b = 8'($urandom);
            rd(ADDR_IRQST_LOW + 8'(i), irq_live[i*8 +: 8]);
            acc(1'b1, ADDR_IRQEN_LOW + 8'(i), b);
            rd(ADDR_IRQEN_LOW + 8'(i), b);
            check({16'h0000, metering_irq_enable[i*8 +: 8]}, {16'h0000, b});
            acc(1'b1, ADDR_IRQST_LOW + 8'(i), b);
        end
        for (w = 1; w < 4; w++) begin
            d = 24'($urandom);
            a = {5'($urandom), 2'(w - 1)};
            acc(1'b1, ADDR_DATA_LOW, d[7:0]);
            acc(1'b1, ADDR_DATA_MID, d[15:8]);
            acc(1'b1, ADDR_DATA_HIGH, d[23:16]);
            acc(1'b1, ADDR_POINTER, {1'b1, a});
            wait_xfer();
            e = d & ((w == 1) ? 24'h0000ff : (w == 2) ? 24'h00ffff : 24'hffffff);
            check(u_metering_core_model.mem[a], e);
            check({23'h0, transfer_busy}, 24'h0);
            rd(ADDR_POINTER, {1'b1, a});
            acc(1'b1, ADDR_DATA_HIGH, ~d[23:16]);
            acc(1'b1, ADDR_POINTER, {1'b0, a});
            wait_xfer();
            rd(ADDR_DATA_LOW, e[7:0]);
            rd(ADDR_DATA_MID, e[15:8]);
            rd(ADDR_DATA_HIGH, e[23:16]);
        end
        stop_test();
    end
endmodule // metering_register_access_test
